// ### shared/ssbe_consts.svh
// Constant definitions for the SPI slave byte engine.
`ifndef SSBE_CONSTS_SVH
`define SSBE_CONSTS_SVH

// ----------------------------------------------------------------------
// Configuration byte fields
// ----------------------------------------------------------------------
`define SSBE_CFG_CPOL 1
`define SSBE_CFG_TRAIL 2
`define SSBE_CFG_SEL 3
`define SSBE_CFG_LSB 7
`define SSBE_MODE0 8'h00
`define SSBE_MODE1 8'h02
`define SSBE_MODE2 8'h04
`define SSBE_MODE3 8'h06
`define SSBE_FW_SELECT_MASK 8'h08
`define SSBE_LSB_FIRST_OPTION 8'h80

// ----------------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------------
`define SSBE_ST_RXF 3
`define SSBE_ST_TXE 4
`define SSBE_ST_DONE 5
`define SSBE_ST_OVR 6
`define SSBE_RX_FULL_STATUS_MASK 8'h08
`define SSBE_TX_EMPTY_STATUS_MASK 8'h10
`define SSBE_DONE_STATUS_MASK 8'h20
`define SSBE_OVERRUN_STATUS_MASK 8'h40

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define SSBE_BYTE_RST 8'h00
`define SSBE_CNT_RST 3'h0
`define SSBE_LAST_BIT 3'h7

`endif

// ### shared/ssbe_pkg.sv
// Types shared by the SPI slave byte engine.
package ssbe_pkg;

    typedef enum logic {
        SSBE_IDLE,
        SSBE_ACTIVE
    } ssbe_link_t;

    typedef struct packed {
        ssbe_link_t link;
        logic [7:0] tx_buf;
        logic [7:0] tx_sh;
        logic [7:0] rx_sh;
        logic [7:0] rx_buf;
        logic [2:0] cnt;
        logic skip;
        logic miso;
        logic txe;
        logic rxf;
        logic done;
        logic ovr;
        logic int_hold;
        logic irq;
    } ssbe_state_t;

endpackage

// ### rtl/ssbe_sync.sv
// Two-flop synchroniser for signals entering from outside the clock.
`timescale 1ns/1ps
module ssbe_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [W-1:0] d, // Asynchronous inputs.
    output logic [W-1:0] q // Synchronised outputs.
);
    logic [W-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST;
            q <= RST;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // ssbe_sync

// ### rtl/ssbe_edge.sv
// Edge detector for a signal already in the clock domain.
`timescale 1ns/1ps
module ssbe_edge #(
    parameter logic RST = 1'b0
) (
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic sig, // Synchronous level.
    output logic rise, // High for the cycle after a rising edge.
    output logic fall // High for the cycle after a falling edge.
);
    logic prev_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= RST;
        end else begin
            prev_q <= sig;
        end
    end

    assign rise = sig & ~prev_q;
    assign fall = ~sig & prev_q;
endmodule // ssbe_edge

// ### rtl/ssbe_engine.sv
// SPI slave byte engine: full-duplex 8-bit slave with buffers and flags.
//
// Summary of operation
// - One full-duplex byte exchanged per transfer.
// - Modes 0/1 sample leading, change trailing.
// - Modes 2/3 sample trailing, change leading.
// - Software picks phase, polarity, bit order.
// - Data out is always driven.
// - Transfers happen only while enabled.
// - Transmit write clears transmit-empty flag, except in a load cycle.
// - Select fall loads shifter, presents first bit.
// - Each active edge shifts one bit.
// - Byte end: receive buffer, reload, flags.
// - Done raises interrupt when enabled.
// - Unread receive byte overwritten sets overrun.
// - Status read clears done, overrun, interrupt.
// - Masking covers completion and load sources.
// - Select from pin or firmware bit.
// - Load mode interrupts when byte loads.
// - Finish mode interrupts after last bit.
// - Status bits 0x20, 0x40, 0x10, 0x08.
// - Config encodes mode and LSB-first bit.
`timescale 1ns/1ps
`include "ssbe_consts.svh"
module ssbe_engine (
    input wire logic sys_clk, // System clock, 250 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic spi_sclk, // Serial clock from the master.
    input wire logic spi_mosi, // Serial data from the master.
    input wire logic spi_ss_n, // Slave select pin, active low.
    output logic spi_miso, // Serial data to the master.
    input wire logic enable, // Engine enable.
    input wire logic [7:0] cfg, // Mode, firmware select, bit order.
    input wire logic firmware_driven_select, // Select from cfg bit.
    input wire logic irq_en, // Interrupt enable.
    input wire logic irq_on_tx_finish, // Transmit interrupt mode.
    input wire logic tx_wr, // Transmit buffer write strobe.
    input wire logic [7:0] tx_data, // Byte to transmit.
    input wire logic rx_rd, // Receive buffer read strobe.
    output logic [7:0] rx_data, // Receive buffer.
    input wire logic status_rd, // Status read strobe.
    output logic [7:0] status, // Status byte.
    output logic irq // Interrupt request.
);
    ssbe_pkg::ssbe_state_t st_q;
    ssbe_pkg::ssbe_state_t st_d;
    logic sclk_s;
    logic mosi_s;
    logic ss_pin_s;
    logic ss_eff;
    logic sclk_rise;
    logic sclk_fall;
    logic ss_rise;
    logic ss_fall;
    logic sel;
    logic lead;
    logic trail;
    logic samp;
    logic chg;
    logic lsb;
    logic load_ev;
    logic done_ev;
    logic [7:0] load_byte;
    logic [7:0] rx_next;

    // ------------------------------------------------------------------
    // Input synchronisation and edge detection
    // ------------------------------------------------------------------
    ssbe_sync #(.W(2), .RST(2'h0)) u_sync_data (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d({spi_sclk, spi_mosi}),
        .q({sclk_s, mosi_s})
    );

    ssbe_sync #(.W(1), .RST(1'b1)) u_sync_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(spi_ss_n),
        .q(ss_pin_s)
    );

    // The firmware bit is already in this domain and needs no crossing.
    assign ss_eff = firmware_driven_select ? cfg[`SSBE_CFG_SEL]
                                           : ss_pin_s;

    ssbe_edge #(.RST(1'b0)) u_edge_sclk (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sig(sclk_s),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );

    ssbe_edge #(.RST(1'b1)) u_edge_sel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sig(ss_eff),
        .rise(ss_rise),
        .fall(ss_fall)
    );

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // The leading edge leaves the idle level, so polarity picks its sense.
    assign lead = cfg[`SSBE_CFG_CPOL] ? sclk_fall : sclk_rise;
    assign trail = cfg[`SSBE_CFG_CPOL] ? sclk_rise : sclk_fall;
    assign samp = cfg[`SSBE_CFG_TRAIL] ? trail : lead;
    assign chg = cfg[`SSBE_CFG_TRAIL] ? lead : trail;
    assign lsb = cfg[`SSBE_CFG_LSB];
    assign sel = enable & ~ss_eff;

    // ------------------------------------------------------------------
    // Transfer events
    // ------------------------------------------------------------------
    assign done_ev = (st_q.link == ssbe_pkg::SSBE_ACTIVE) & sel & samp
                     & (st_q.cnt == `SSBE_LAST_BIT);
    assign load_ev = ((st_q.link == ssbe_pkg::SSBE_IDLE) & sel & ss_fall)
                     | done_ev;
    // A write in the load cycle goes straight to the shifter.
    assign load_byte = tx_wr ? tx_data : st_q.tx_buf;
    assign rx_next = lsb ? {mosi_s, st_q.rx_sh[7:1]}
                         : {st_q.rx_sh[6:0], mosi_s};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (tx_wr) begin
            st_d.tx_buf = tx_data;
            st_d.txe = 1'b0;
        end
        case (st_q.link)
            ssbe_pkg::SSBE_IDLE: begin
                st_d.cnt = `SSBE_CNT_RST;
                if (sel && ss_fall) begin
                    st_d.link = ssbe_pkg::SSBE_ACTIVE;
                end
            end
            ssbe_pkg::SSBE_ACTIVE: begin
                if (!sel) begin
                    st_d.link = ssbe_pkg::SSBE_IDLE;
                    st_d.cnt = `SSBE_CNT_RST;
                end else begin
                    if (samp) begin
                        st_d.rx_sh = rx_next;
                        st_d.cnt = st_q.cnt + 3'h1;
                    end
                    if (chg) begin
                        if (st_q.skip) begin
                            st_d.skip = 1'b0;
                        end else if (lsb) begin
                            st_d.tx_sh = {1'b0, st_q.tx_sh[7:1]};
                            st_d.miso = st_q.tx_sh[1];
                        end else begin
                            st_d.tx_sh = {st_q.tx_sh[6:0], 1'b0};
                            st_d.miso = st_q.tx_sh[6];
                        end
                    end
                end
            end
            default: begin
                st_d.link = ssbe_pkg::SSBE_IDLE;
            end
        endcase
        // A change edge before the next sample would push out the first
        // bit just loaded, so that one edge is skipped.
        if (load_ev) begin
            st_d.tx_sh = load_byte;
            st_d.miso = lsb ? load_byte[0] : load_byte[7];
            st_d.skip = done_ev | cfg[`SSBE_CFG_TRAIL];
            if (tx_wr) begin
                st_d.tx_buf = tx_data;
            end
        end
        if (rx_rd) begin
            st_d.rxf = 1'b0;
        end
        if (status_rd) begin
            st_d.done = 1'b0;
            st_d.ovr = 1'b0;
            st_d.int_hold = 1'b0;
        end
        // Hardware sets come last so they win over clears.
        if (load_ev) begin
            st_d.txe = 1'b1;
        end
        if (done_ev) begin
            st_d.rx_buf = rx_next;
            st_d.rxf = 1'b1;
            st_d.done = 1'b1;
            if (st_q.rxf && !rx_rd) begin
                st_d.ovr = 1'b1;
            end
            if (irq_en) begin
                st_d.int_hold = 1'b1;
            end
        end
        // The load source bypasses the held line but is still masked by irq_en.
        st_d.irq = st_d.int_hold
                   | (irq_en & ~irq_on_tx_finish & load_ev);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{link: ssbe_pkg::SSBE_IDLE,
                      tx_buf: `SSBE_BYTE_RST,
                      tx_sh: `SSBE_BYTE_RST,
                      rx_sh: `SSBE_BYTE_RST,
                      rx_buf: `SSBE_BYTE_RST,
                      cnt: `SSBE_CNT_RST,
                      skip: 1'b0,
                      miso: 1'b0,
                      txe: 1'b1,
                      rxf: 1'b0,
                      done: 1'b0,
                      ovr: 1'b0,
                      int_hold: 1'b0,
                      irq: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Data out is never released; any tri-state buffer sits outside.
    assign spi_miso = st_q.miso;
    assign rx_data = st_q.rx_buf;
    assign irq = st_q.irq;
    always_comb begin
        status = 8'h00;
        status[`SSBE_ST_RXF] = st_q.rxf;
        status[`SSBE_ST_TXE] = st_q.txe;
        status[`SSBE_ST_DONE] = st_q.done;
        status[`SSBE_ST_OVR] = st_q.ovr;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_select_load: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st_q.link == ssbe_pkg::SSBE_IDLE && sel && ss_fall && !tx_wr)
        |=> (spi_miso == ($past(cfg[`SSBE_CFG_LSB]) ? $past(st_q.tx_buf[0])
                                                   : $past(st_q.tx_buf[7])))
            && st_q.txe && st_q.cnt == `SSBE_CNT_RST)
        else $error("first bit not presented after select fall");

    a_write_clears: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (tx_wr && !load_ev) |=> !st_q.txe && st_q.tx_buf == $past(tx_data))
        else $error("transmit write did not clear empty flag");

    a_byte_done: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        done_ev |=> st_q.done && st_q.rxf && st_q.rx_buf == $past(rx_next)
                    && st_q.cnt == `SSBE_CNT_RST)
        else $error("byte end did not update buffer and flags");

    a_done_irq: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (done_ev && irq_en) |=> irq ##1 (irq || $past(status_rd)))
        else $error("done did not raise interrupt");

    a_overrun_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (done_ev && st_q.rxf && !rx_rd) |=> st_q.ovr)
        else $error("overrun not flagged");

    a_status_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (status_rd && !done_ev) |=> !st_q.done && !st_q.ovr
                                    && !st_q.int_hold)
        else $error("status read did not clear flags");

    a_disabled_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !enable |=> st_q.link == ssbe_pkg::SSBE_IDLE && !$rose(st_q.done))
        else $error("engine active while disabled");

    a_deselect_flush: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (ss_eff && !($past(ss_eff))) |=> st_q.cnt == `SSBE_CNT_RST
                                         && !$rose(st_q.done))
        else $error("partial byte kept after deselect");

    a_load_irq: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (load_ev && irq_en && !irq_on_tx_finish) |=> irq)
        else $error("load mode interrupt missing");

    a_finish_wait: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (irq_on_tx_finish && !st_q.int_hold && !done_ev) |=> !irq)
        else $error("finish mode interrupt before last bit");

    a_mid_shift: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st_q.link == ssbe_pkg::SSBE_ACTIVE && sel && chg && !load_ev
         && st_q.cnt != `SSBE_CNT_RST)
        |=> spi_miso == ($past(lsb) ? $past(st_q.tx_sh[1])
                                    : $past(st_q.tx_sh[6])))
        else $error("data out did not shift inside a byte");

    a_first_stands: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st_q.link == ssbe_pkg::SSBE_ACTIVE && sel && chg && !load_ev
         && st_q.cnt == `SSBE_CNT_RST) |=> $stable(spi_miso))
        else $error("first bit of a byte did not stand");

    a_miso_steady: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!load_ev && !(st_q.link == ssbe_pkg::SSBE_ACTIVE && sel && chg))
        |=> $stable(spi_miso))
        else $error("data out moved without a change edge");

    a_sample_in: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (st_q.link == ssbe_pkg::SSBE_ACTIVE && sel && samp)
        |=> st_q.cnt == $past(st_q.cnt) + 3'h1
            && ($past(lsb) ? st_q.rx_sh[7] : st_q.rx_sh[0]) == $past(mosi_s))
        else $error("sample edge did not take one bit");

    a_fw_select: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (firmware_driven_select && cfg[`SSBE_CFG_SEL])
        |=> st_q.link == ssbe_pkg::SSBE_IDLE)
        else $error("firmware deselect left the engine active");

    a_rx_read: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (rx_rd && !done_ev) |=> !st_q.rxf)
        else $error("receive read did not clear full flag");

    a_reload_byte: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        done_ev |=> spi_miso == ($past(lsb) ? $past(load_byte[0])
                                            : $past(load_byte[7])))
        else $error("next byte not presented after byte end");
endmodule // ssbe_engine

// ### sim/ssbe_master_model.sv
// Behavioural SPI master that drives the slave engine's link pins.
`timescale 1ns/1ps
module ssbe_master_model (
    output logic spi_sclk, // Serial clock to the slave.
    output logic spi_mosi, // Serial data to the slave.
    output logic spi_ss_n, // Slave select pin, active low.
    input wire logic spi_miso // Serial data from the slave.
);
    localparam realtime HALF = 62.5;

    initial begin
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
        spi_ss_n = 1'b1;
    end

    // ------------------------------------------------------------------
    // One selection of nb bits; byte 0 sits in mo[15:8].
    // ------------------------------------------------------------------
    task automatic frame(input logic [7:0] c, input int nb,
        input logic [15:0] mo, input logic pin, output logic [15:0] mi);
        int idx;
        mi = 16'h0000;
        spi_sclk <= c[1];
        #HALF;
        if (pin) spi_ss_n <= 1'b0;
        for (int b = 0; b < nb; b++) begin
            idx = 8 - 8 * (b / 8) + (c[7] ? b % 8 : 7 - b % 8);
            if (!c[2]) spi_mosi <= mo[idx];
            #HALF;
            spi_sclk <= ~c[1];
            if (c[2]) spi_mosi <= mo[idx];
            else mi[idx] = spi_miso;
            #HALF;
            spi_sclk <= c[1];
            if (c[2]) mi[idx] = spi_miso;
        end
        #HALF;
        if (pin) spi_ss_n <= 1'b1;
        // Released data line shows the inverse of its last level.
        spi_mosi <= ~spi_mosi;
        #HALF;
    endtask
endmodule // ssbe_master_model

// ### sim/tb_ssbe_engine.sv
// Self-checking bench for the SPI slave byte engine.
`timescale 1ns/1ps
module tb_ssbe_engine;
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] tx;
        logic [7:0] mo;
    } ssbe_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic spi_sclk;
    logic spi_mosi;
    logic spi_ss_n;
    logic spi_miso;
    logic enable = 1'b0;
    logic [7:0] cfg = 8'h00;
    logic firmware_driven_select = 1'b0;
    logic irq_en = 1'b1;
    logic irq_on_tx_finish = 1'b1;
    logic tx_wr = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_rd = 1'b0;
    logic status_rd = 1'b0;
    logic [7:0] rx_data;
    logic [7:0] status;
    logic irq;
    logic irq_prev = 1'b0;
    int irq_rises = 0;
    int errors = 0;
    int checked = 0;
    int n0;
    logic [15:0] mi;
    ssbe_row_t rows [4] = '{'{8'h00, 8'ha5, 8'h3c}, '{8'h82, 8'h5b, 8'hc1},
        '{8'h04, 8'h96, 8'h0f}, '{8'h86, 8'h1e, 8'hf0}};

    always #2 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        irq_prev <= irq;
        if (irq === 1'b1 && irq_prev === 1'b0) irq_rises <= irq_rises + 1;
    end

    ssbe_engine ssbe_engine_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n),
        .spi_miso(spi_miso), .enable(enable), .cfg(cfg),
        .firmware_driven_select(firmware_driven_select), .irq_en(irq_en),
        .irq_on_tx_finish(irq_on_tx_finish), .tx_wr(tx_wr),
        .tx_data(tx_data), .rx_rd(rx_rd), .rx_data(rx_data),
        .status_rd(status_rd), .status(status), .irq(irq));

    ssbe_master_model ssbe_master_model_i (.spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n), .spi_miso(spi_miso));

    // ------------------------------------------------------------------
    // Helper tasks.
    // ------------------------------------------------------------------
    task automatic stop_test();
        if (errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] b);
        @(posedge sys_clk);
        tx_data <= b;
        tx_wr <= 1'b1;
        @(posedge sys_clk);
        tx_wr <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic strobe(input logic s, input logic r);
        @(posedge sys_clk);
        status_rd <= s;
        rx_rd <= r;
        @(posedge sys_clk);
        status_rd <= 1'b0;
        rx_rd <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic run(input logic [7:0] c, input int nb,
        input logic [15:0] mo);
        @(posedge sys_clk);
        cfg <= c;
        ssbe_master_model_i.frame(c, nb, mo, 1'b1, mi);
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    initial begin
        #60us;
        errors++;
        stop_test();
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        chk({spi_miso, irq, status}, 16'h0010);
        chk(rx_data, 8'h00);
        @(posedge sys_clk);
        enable <= 1'b1;
        foreach (rows[i]) begin
            send(rows[i].tx);
            chk(status, 8'h00);
            run(rows[i].cfg, 8, {rows[i].mo, 8'h00});
            chk(mi[15:8], rows[i].tx);
            chk(rx_data, rows[i].mo);
            chk({irq, status}, 16'h0138);
            strobe(1'b1, 1'b1);
            chk({irq, status}, 16'h0010);
        end
        send(8'hc3);
        fork
            run(8'h04, 16, 16'h5a96);
            begin
                repeat (40) @(posedge sys_clk);
                send(8'h7e);
            end
        join
        chk(mi, 16'hc37e);
        chk(rx_data, 8'h96);
        chk({irq, status}, 16'h0178);
        strobe(1'b1, 1'b1);
        @(posedge sys_clk);
        irq_on_tx_finish <= 1'b0;
        send(8'h81);
        n0 = irq_rises;
        run(8'h00, 4, 16'hffff);
        chk(16'(irq_rises - n0), 16'h0001);
        chk(status, 8'h10);
        @(posedge sys_clk);
        irq_on_tx_finish <= 1'b1;
        send(8'h24);
        n0 = irq_rises;
        run(8'h00, 8, 16'h6900);
        chk(mi[15:8], 8'h24);
        chk(rx_data, 8'h69);
        chk(16'(irq_rises - n0), 16'h0001);
        strobe(1'b1, 1'b1);
        @(posedge sys_clk);
        enable <= 1'b0;
        send(8'h11);
        run(8'h00, 8, 16'h3300);
        chk(rx_data, 8'h69);
        chk({irq, status}, 16'h0000);
        @(posedge sys_clk);
        enable <= 1'b1;
        irq_en <= 1'b0;
        cfg <= 8'h08;
        firmware_driven_select <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cfg <= 8'h00;
        ssbe_master_model_i.frame(8'h00, 8, 16'hd200, 1'b0, mi);
        @(posedge sys_clk);
        cfg <= 8'h08;
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(mi[15:8], 8'h11);
        chk(rx_data, 8'hd2);
        chk({irq, status}, 16'h0038);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(negedge sys_clk);
        chk({spi_miso, irq, status}, 16'h0010);
        chk(rx_data, 8'h00);
        stop_test();
    end
endmodule // tb_ssbe_engine
